//--- design/accel_regs_cfg.svh
// register offsets, field positions and reset values of the register bank
`ifndef ACCEL_REGS_CFG_SVH
`define ACCEL_REGS_CFG_SVH
`define ADDR_RANGE_CHECK 8'h23
`define ADDR_SLEEP_WAKE 8'h24
`define ADDR_HP_RESET 8'h25
`define ADDR_HP_REF 8'h26
`define ADDR_SAMPLE_FLAGS 8'h27
`define ADDR_X_OUT 8'h29
`define ADDR_Y_OUT 8'h2B
`define ADDR_Z_OUT 8'h2D
`define ADDR_INTR1_CFG 8'h30
`define ADDR_INTR1_SRC 8'h31
`define ADDR_INTR1_LEVEL 8'h32
`define ADDR_INTR1_PERSIST 8'h33
`define RANGE_MSB 5
`define RANGE_LSB 4
`define EXCITE_POL_BIT 3
`define EXCITE_EN_BIT 1
`define SPI_WIRE_BIT 0
`define RANGE_CHECK_MASK 8'h3B
`define SRC_ACTIVE_BIT 6
`define CFG_AOI_BIT 7
`define CFG_6D_BIT 6
`define HP_MODE_REF 2'h1
`define HP_SHIFT_BASE 4'h3
`define REG_RESET 8'h00
`endif

//--- design/accel_regs_pkg.sv
// types shared by the accelerometer register bank
package accel_regs_pkg;
   typedef enum logic [1:0] {CMB_OR, CMB_MOVE, CMB_AND, CMB_POS} comb_mode_t;
   typedef struct packed {
      logic [7:0] ctrl4_r;
      logic [1:0] sleep_r;
      logic [7:0] ref_r;
      logic [7:0] cfg_r;
      logic [6:0] level_r;
      logic [6:0] persist_r;
      logic [2:0][7:0] out_r;
      logic [2:0][7:0] base_r;
      logic [2:0] new_r;
      logic [2:0] ovr_r;
      logic xyz_ovr_r;
      logic [5:0] src_r;
      logic active_r;
      logic [6:0] cnt_r;
      logic [5:0] prev_r;
      logic [7:0] rdata_r;
   } state_t;
endpackage : accel_regs_pkg

//--- design/accel_config_intr1_regs.sv
// accelerometer control, status, output and interrupt 1 register bank
//
// Behaviour
// - range field 00/01/11 selects 2/4/8 g
// - excitation polarity bit: 0 positive, 1 negative
// - excitation only while enable bit is 1
// - wire select bit: 0 four-wire, 1 three-wire
// - two low sleep-wake bits, upper six zero
// - reading filter-reset address clears filter state
// - filter-reset read forces filtered outputs to zero
// - mode 01 filters against stored reference value
// - writable 8-bit reference, resets to zero
// - set-overrun when unread set is overwritten
// - per-axis overrun when unread sample overwritten
// - set-new flag high when all axes new
// - per-axis new flag on each sample
// - outputs are 8-bit two's complement per axis
// - per-axis above and below event enables
// - combiner: OR, movement, AND, position modes
// - active flag on generated event, bit 7 zero
// - source byte reports each enabled axis event
// - source read clears active flag and pin
// - source register ignores host writes
// - 7-bit level, top bit reads zero
// - 7-bit persistence value before recognition
// - latch option holds source until read
// - interrupt source may use filtered data
// - output registers may take filtered data
`include "accel_regs_cfg.svh"

module accel_config_intr1_regs #(
   parameter int DATA_W = 8,
   parameter int LEVEL_W = 7
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port from the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // samples from the sensing chain
   input wire logic sample_valid_i,
   input wire logic [DATA_W-1:0] x_raw_i,
   input wire logic [DATA_W-1:0] y_raw_i,
   input wire logic [DATA_W-1:0] z_raw_i,
   // filter and interrupt controls held elsewhere
   input wire logic filtered_out_sel_i,
   input wire logic highpass_for_intr1_i,
   input wire logic highpass_for_intr2_i,
   input wire logic [1:0] highpass_filter_mode_sel_i,
   input wire logic [1:0] hp_cutoff_sel_i,
   input wire logic latch_intr1_req_i,
   // control outputs to the analog front end and serial port
   output logic [1:0] full_range_sel_o,
   output logic check_excite_en_o,
   output logic check_excite_polarity_o,
   output logic spi_wire_select_o,
   output logic [1:0] sleep_wake_sel_o,
   // interrupt 1 pin level, active high
   output logic intr1_o
);
   import accel_regs_pkg::*;

   if (DATA_W != 8 || LEVEL_W != 7)
   begin : g_width_check
      $error("register bank supports only 8-bit data and 7-bit level");
   end

   state_t st_r;
   state_t st_nxt;
   logic [2:0][7:0] raw_w;
   logic [2:0][7:0] filt_w;
   logic [2:0][7:0] base_nxt_w;
   logic [5:0] evt_w;
   logic [5:0] act_w;
   logic [5:0] en_w;
   logic filt_on_w;
   logic ref_mode_w;
   logic six_dir_w;
   logic cond_w;
   logic recog_w;
   logic [3:0] shift_w;
   comb_mode_t mode_w;

   function automatic logic [7:0] sat8(input logic [8:0] v);
      if (v[8] != v[7])
      begin
         return v[8] ? 8'h80 : 8'h7F;
      end
      return v[7:0];
   endfunction

   assign raw_w = {z_raw_i, y_raw_i, x_raw_i};
   // reference mode needs a filter consumer; dc tracking runs on every sample
   assign filt_on_w = filtered_out_sel_i | highpass_for_intr1_i |
                      highpass_for_intr2_i;
   assign ref_mode_w = filt_on_w &&
                       highpass_filter_mode_sel_i == `HP_MODE_REF;
   assign shift_w = `HP_SHIFT_BASE + {2'h0, hp_cutoff_sel_i};
   assign en_w = st_r.cfg_r[5:0];
   assign mode_w = comb_mode_t'({st_r.cfg_r[`CFG_AOI_BIT],
                                 st_r.cfg_r[`CFG_6D_BIT]});
   assign six_dir_w = st_r.cfg_r[`CFG_6D_BIT];

   for (genvar a = 0; a < 3; a++)
   begin : g_axis
      logic [8:0] d_base;
      logic [8:0] d_ref;
      logic [7:0] step;
      logic [7:0] evv;
      logic [7:0] mag;
      logic above;
      logic pos_hi;
      logic pos_lo;
      assign d_base = {raw_w[a][7], raw_w[a]} -
                      {st_r.base_r[a][7], st_r.base_r[a]};
      assign d_ref = {raw_w[a][7], raw_w[a]} - {st_r.ref_r[7], st_r.ref_r};
      assign filt_w[a] = sat8(ref_mode_w ? d_ref : d_base);
      // first-order tracking of the dc level; shift sets the cut-off
      assign step = 8'($signed(sat8(d_base)) >>> shift_w);
      assign base_nxt_w[a] = st_r.base_r[a] + step;
      assign evv = highpass_for_intr1_i ? filt_w[a] : raw_w[a];
      assign mag = evv[7] ? 8'(-evv) : evv;
      assign above = mag > {1'b0, st_r.level_r};
      // six-direction modes need the sign, the others the magnitude
      assign pos_hi = $signed(evv) > $signed({1'b0, st_r.level_r});
      assign pos_lo = $signed({evv[7], evv}) <
                      -$signed({2'h0, st_r.level_r});
      assign evt_w[2*a+1] = six_dir_w ? pos_hi : above;
      assign evt_w[2*a] = six_dir_w ? pos_lo : ~above;
   end

   assign act_w = evt_w & en_w;

   always_comb
   begin
      unique case (mode_w)
         CMB_OR: cond_w = |act_w;
         CMB_AND: cond_w = (|en_w) && (act_w == en_w);
         CMB_MOVE: cond_w = (|act_w) && (act_w != st_r.prev_r);
         CMB_POS: cond_w = |act_w;
      endcase
   end

   // dur 0 fires at once; dur n needs n earlier qualifying samples
   assign recog_w = cond_w && st_r.cnt_r >= st_r.persist_r;

   always_comb
   begin
      logic rd_src;
      logic rd_rst;
      logic [2:0] rd_out;
      rd_src = reg_rd_i && reg_addr_i == `ADDR_INTR1_SRC;
      rd_rst = reg_rd_i && reg_addr_i == `ADDR_HP_RESET;
      rd_out[0] = reg_rd_i && reg_addr_i == `ADDR_X_OUT;
      rd_out[1] = reg_rd_i && reg_addr_i == `ADDR_Y_OUT;
      rd_out[2] = reg_rd_i && reg_addr_i == `ADDR_Z_OUT;
      st_nxt = st_r;

      if (reg_wr_i)
      begin
         case (reg_addr_i)
            `ADDR_RANGE_CHECK:
               st_nxt.ctrl4_r = reg_wdata_i & `RANGE_CHECK_MASK;
            `ADDR_SLEEP_WAKE: st_nxt.sleep_r = reg_wdata_i[1:0];
            `ADDR_HP_REF: st_nxt.ref_r = reg_wdata_i;
            `ADDR_INTR1_CFG: st_nxt.cfg_r = reg_wdata_i;
            `ADDR_INTR1_LEVEL: st_nxt.level_r = reg_wdata_i[6:0];
            `ADDR_INTR1_PERSIST: st_nxt.persist_r = reg_wdata_i[6:0];
            default: ; // source, status and outputs ignore writes
         endcase
      end

      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `ADDR_RANGE_CHECK: st_nxt.rdata_r = st_r.ctrl4_r;
            `ADDR_SLEEP_WAKE: st_nxt.rdata_r = {6'h00, st_r.sleep_r};
            `ADDR_HP_REF: st_nxt.rdata_r = st_r.ref_r;
            `ADDR_SAMPLE_FLAGS:
               st_nxt.rdata_r = {st_r.xyz_ovr_r, st_r.ovr_r[2],
                                 st_r.ovr_r[1], st_r.ovr_r[0],
                                 &st_r.new_r, st_r.new_r[2],
                                 st_r.new_r[1], st_r.new_r[0]};
            `ADDR_X_OUT: st_nxt.rdata_r = st_r.out_r[0];
            `ADDR_Y_OUT: st_nxt.rdata_r = st_r.out_r[1];
            `ADDR_Z_OUT: st_nxt.rdata_r = st_r.out_r[2];
            `ADDR_INTR1_CFG: st_nxt.rdata_r = st_r.cfg_r;
            `ADDR_INTR1_SRC:
               st_nxt.rdata_r = {1'b0, st_r.active_r, st_r.src_r};
            `ADDR_INTR1_LEVEL: st_nxt.rdata_r = {1'b0, st_r.level_r};
            `ADDR_INTR1_PERSIST: st_nxt.rdata_r = {1'b0, st_r.persist_r};
            default: st_nxt.rdata_r = `REG_RESET; // incl. filter reset
         endcase
      end

      // clears first so that a same-cycle sample wins
      for (int a = 0; a < 3; a++)
      begin
         if (rd_out[a])
         begin
            st_nxt.new_r[a] = 1'b0;
            st_nxt.ovr_r[a] = 1'b0;
         end
      end
      if (|rd_out)
      begin
         st_nxt.xyz_ovr_r = 1'b0;
      end
      if (rd_src)
      begin
         st_nxt.active_r = 1'b0;
      end

      if (sample_valid_i)
      begin
         for (int a = 0; a < 3; a++)
         begin
            st_nxt.ovr_r[a] = st_r.ovr_r[a] | st_r.new_r[a];
            st_nxt.new_r[a] = 1'b1;
            st_nxt.out_r[a] = filtered_out_sel_i ? filt_w[a] : raw_w[a];
            st_nxt.base_r[a] = base_nxt_w[a];
         end
         if (&st_r.new_r)
         begin
            st_nxt.xyz_ovr_r = 1'b1;
         end
         st_nxt.cnt_r = cond_w ?
            (&st_r.cnt_r ? st_r.cnt_r : st_r.cnt_r + 7'h01) : 7'h00;
         st_nxt.prev_r = act_w;
         if (latch_intr1_req_i)
         begin
            // held flags refresh only once the host has read them
            if (recog_w && (!st_r.active_r || rd_src))
            begin
               st_nxt.src_r = act_w;
               st_nxt.active_r = 1'b1;
            end
         end
         else
         begin
            st_nxt.src_r = act_w;
            if (recog_w)
            begin
               st_nxt.active_r = 1'b1;
            end
            else if (!rd_src)
            begin
               st_nxt.active_r = 1'b0;
            end
         end
      end

      if (rd_rst)
      begin
         for (int a = 0; a < 3; a++)
         begin
            st_nxt.base_r[a] = raw_w[a];
            if (filtered_out_sel_i)
            begin
               st_nxt.out_r[a] = 8'h00;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_o = st_r.rdata_r;
   assign full_range_sel_o = st_r.ctrl4_r[`RANGE_MSB:`RANGE_LSB];
   assign check_excite_en_o = st_r.ctrl4_r[`EXCITE_EN_BIT];
   assign check_excite_polarity_o = st_r.ctrl4_r[`EXCITE_POL_BIT];
   assign spi_wire_select_o = st_r.ctrl4_r[`SPI_WIRE_BIT];
   assign sleep_wake_sel_o = st_r.sleep_r;
   assign intr1_o = st_r.active_r;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   wire wr_ctrl4 = reg_wr_i && reg_addr_i == `ADDR_RANGE_CHECK;

   range_write_a: assert property (
      wr_ctrl4 |=> full_range_sel_o == $past(reg_wdata_i[5:4]))
      else $error("range field not taken from write");
   excite_pol_a: assert property (
      wr_ctrl4 |=> check_excite_polarity_o == $past(reg_wdata_i[3]))
      else $error("excitation polarity not taken from write");
   excite_en_a: assert property (
      wr_ctrl4 ##1 !reg_wr_i |=> check_excite_en_o == $past(reg_wdata_i[1], 2))
      else $error("excitation enable not held");
   wire_sel_a: assert property (
      wr_ctrl4 |=> spi_wire_select_o == $past(reg_wdata_i[0]))
      else $error("wire select not taken from write");
   sleep_upper_a: assert property (
      reg_rd_i && reg_addr_i == `ADDR_SLEEP_WAKE |=> reg_rdata_o[7:2] == 6'h00)
      else $error("sleep-wake upper bits not zero");
   hp_reset_out_a: assert property (
      reg_rd_i && reg_addr_i == `ADDR_HP_RESET && filtered_out_sel_i
      |=> st_r.out_r == '0)
      else $error("filter reset did not zero outputs");
   ref_store_a: assert property (
      reg_wr_i && reg_addr_i == `ADDR_HP_REF
      ##1 reg_rd_i && reg_addr_i == `ADDR_HP_REF && !reg_wr_i
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("reference readback mismatch");
   set_overrun_a: assert property (
      sample_valid_i && (&st_r.new_r) |=> st_r.xyz_ovr_r)
      else $error("set overrun not flagged");
   new_sample_a: assert property (
      sample_valid_i |=> st_r.new_r == 3'h7 [*1] ##0 (&st_r.new_r))
      else $error("new-sample flags not set");
   src_clear_a: assert property (
      reg_rd_i && reg_addr_i == `ADDR_INTR1_SRC && !sample_valid_i
      |=> !intr1_o)
      else $error("source read did not drop interrupt");
   src_ro_a: assert property (
      reg_wr_i && reg_addr_i == `ADDR_INTR1_SRC && !sample_valid_i
      |=> $stable(st_r.src_r))
      else $error("write altered source flags");
   level_top_a: assert property (
      reg_rd_i && reg_addr_i == `ADDR_INTR1_LEVEL |=> !reg_rdata_o[7])
      else $error("level top bit not zero");
   intr_rise_a: assert property (
      $rose(intr1_o) |-> $past(sample_valid_i) && $past(recog_w))
      else $error("interrupt rose without recognised event");
   out_clear_a: assert property (
      reg_rd_i && reg_addr_i == `ADDR_X_OUT && !sample_valid_i
      |=> !st_r.new_r[0] && !st_r.ovr_r[0])
      else $error("x read did not clear its flags");

   latched_irq_c: cover property (
      latch_intr1_req_i && $rose(intr1_o) ##[1:20] !intr1_o);
   and_mode_c: cover property (mode_w == CMB_AND && recog_w && sample_valid_i);
   overrun_c: cover property ($rose(st_r.xyz_ovr_r));
   hp_reset_c: cover property (reg_rd_i && reg_addr_i == `ADDR_HP_RESET);
endmodule // accel_config_intr1_regs

//--- testbench/host_bus_model.sv
// host side of the register port: single byte reads and writes
module host_bus_model (
   // clock
   input wire logic clk_i,
   // register port towards the bank
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end

   // idle address and data show the inverse, never a stale match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask

   // one strobe per read: source and filter reads have side effects
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
   endtask
endmodule // host_bus_model

//--- testbench/testbench.sv
// self-checking bench for the accelerometer register bank
`include "accel_regs_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_n_i;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, smp, fos, hp1, hp2, lir, intr1;
   logic [1:0] highpass_filter_mode_sel, cut, fsel, sleep;
   logic en, pol, spi;
   logic [7:0] x_raw, y_raw, z_raw;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] rst_regs [8] = '{8'h23, 8'h24, 8'h26, 8'h27,
                                8'h30, 8'h31, 8'h32, 8'h33};
   // config, x sample, y sample, expected source byte
   logic [31:0] tbl [8] = '{32'h02200042, 32'h01050041, 32'h8A200002,
                            32'h8A20204A, 32'hC2200042, 32'h42200002,
                            32'h42000000, 32'h42200042};

   always #5 clk_i = ~clk_i;

   host_bus_model host (
      .clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));

   accel_config_intr1_regs DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .sample_valid_i(smp), .x_raw_i(x_raw), .y_raw_i(y_raw),
      .z_raw_i(z_raw), .filtered_out_sel_i(fos),
      .highpass_for_intr1_i(hp1), .highpass_for_intr2_i(hp2),
      .highpass_filter_mode_sel_i(highpass_filter_mode_sel), .hp_cutoff_sel_i(cut),
      .latch_intr1_req_i(lir), .full_range_sel_o(fsel),
      .check_excite_en_o(en), .check_excite_polarity_o(pol),
      .spi_wire_select_o(spi), .sleep_wake_sel_o(sleep), .intr1_o(intr1));

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic rc(string n, logic [7:0] a, logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk(n, v, exp);
   endtask

   task automatic samp(logic [7:0] x, logic [7:0] y, logic [7:0] z);
      @(posedge clk_i);
      #1;
      x_raw = x;
      y_raw = y;
      z_raw = z;
      smp = 1'b1;
      @(posedge clk_i);
      #1;
      smp = 1'b0;
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      print_verdict();
   end

   initial
   begin
      rst_n_i = 1'b0;
      smp = 1'b0;
      {x_raw, y_raw, z_raw} = '0;
      {fos, hp1, hp2, lir} = '0;
      highpass_filter_mode_sel = 2'h0;
      cut = 2'h0;
      repeat (4) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      chk("ctrl pins", {1'b0, fsel, pol, en, spi, sleep}, 8'h00);
      foreach (rst_regs[i])
         rc("reset value", rst_regs[i], `REG_RESET);
      $display("test reset done");

      for (int c = 0; c < 4; c++)
      begin
         if (c == 2)
            continue;
         host.wr(8'h23, {2'h0, c[1:0], 4'h0});
         chk("range pins", {6'h00, fsel}, {6'h00, c[1:0]});
      end
      host.wr(8'h23, 8'hFF);
      rc("ctrl4", 8'h23, 8'h3B);
      chk("ctrl pins", {3'h0, fsel, pol, en, spi}, 8'h1F);
      host.wr(8'h23, 8'h08);
      chk("ctrl pins", {3'h0, fsel, pol, en, spi}, 8'h04);
      host.wr(8'h24, 8'hFF);
      rc("ctrl5", 8'h24, 8'h03);
      chk("sleep pins", {6'h00, sleep}, 8'h03);
      host.wr(8'h26, 8'hA5);
      rc("reference", 8'h26, 8'hA5);
      host.wr(8'h32, 8'hFF);
      rc("level", 8'h32, 8'h7F);
      host.wr(8'h33, 8'hFF);
      rc("persist", 8'h33, 8'h7F);
      host.wr(8'h33, 8'h00);
      host.wr(8'h32, 8'h10);
      host.wr(8'h25, 8'hFF);
      host.wr(8'h27, 8'hFF);
      host.wr(8'h31, 8'hFF);
      rc("flags", 8'h27, 8'h00);
      rc("source", 8'h31, 8'h00);
      rc("unmapped", 8'h40, 8'h00);
      rc("filter reset", 8'h25, 8'h00);
      $display("test registers done");

      samp(8'h05, 8'hFB, 8'h80);
      rc("flags", 8'h27, 8'h0F);
      rc("x out", 8'h29, 8'h05);
      rc("y out", 8'h2B, 8'hFB);
      rc("z out", 8'h2D, 8'h80);
      rc("flags", 8'h27, 8'h00);
      samp(8'h05, 8'hFB, 8'h80);
      samp(8'h05, 8'hFB, 8'h80);
      rc("flags", 8'h27, 8'hFF);
      rc("x out", 8'h29, 8'h05);
      rc("flags", 8'h27, 8'h66);
      $display("test status done");

      foreach (tbl[i])
      begin
         host.wr(8'h30, tbl[i][31:24]);
         samp(tbl[i][23:16], tbl[i][15:8], 8'h00);
         if (i == 0)
            host.wr(8'h31, 8'hFF);
         chk("pin", {7'h00, intr1}, {7'h00, tbl[i][6]});
         rc("source", 8'h31, tbl[i][7:0]);
         chk("pin", {7'h00, intr1}, 8'h00);
      end
      $display("test combiner done");

      host.wr(8'h30, 8'h02);
      samp(8'h00, 8'h00, 8'h00);
      host.wr(8'h33, 8'h02);
      samp(8'h20, 8'h00, 8'h00);
      samp(8'h20, 8'h00, 8'h00);
      chk("pin", {7'h00, intr1}, 8'h00);
      samp(8'h20, 8'h00, 8'h00);
      chk("pin", {7'h00, intr1}, 8'h01);
      rc("source", 8'h31, 8'h42);
      host.wr(8'h33, 8'h00);
      lir = 1'b1;
      samp(8'h20, 8'h00, 8'h00);
      samp(8'h00, 8'h00, 8'h00);
      chk("pin", {7'h00, intr1}, 8'h01);
      rc("source", 8'h31, 8'h42);
      chk("pin", {7'h00, intr1}, 8'h00);
      lir = 1'b0;
      $display("test persist and latch done");

      // reference mode: outputs are raw minus the stored reference
      fos = 1'b1;
      highpass_filter_mode_sel = `HP_MODE_REF;
      host.wr(8'h26, 8'h10);
      samp(8'h30, 8'h00, 8'h05);
      rc("x out", 8'h29, 8'h20);
      rc("y out", 8'h2B, 8'hF0);
      rc("z out", 8'h2D, 8'hF5);
      highpass_filter_mode_sel = 2'h0;
      rc("filter reset", 8'h25, 8'h00);
      rc("x out", 8'h29, 8'h00);
      samp(8'h30, 8'h00, 8'h05);
      rc("z out", 8'h2D, 8'h00);
      $display("test filter done");
      print_verdict();
   end
endmodule // testbench
